//--- logic/press_cycle_release_control.sv
// Contract
// - Overrun check only with stop cam enabled.
// - Drive rise in window or high accepted.
// - Failed check: release low, overrun error high.
// - Inhibit without error: release low, checks off.
// - Inhibit with error lets error clear.
// - Inhibit falling without error returns monitor release high.
// - Restart interlock has four selectable choices.
// - Minimum restart pulse is 100 or 350 ms.
// - Start release gates setting release only.
// - Single stroke: top rise drops release.
// - Start rise requests start, low stops.
// - Start-low stop needs restart in that mode.
// - Static release low drops release immediately.
// - Restart pulse between minimum and 30 s.
// - No restart pending: start rise sets release.
// - Restart pending output; inverted static output.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module press_cycle_release_control #(
    parameter int unsigned short_cyc = press_release_pkg::short_cyc,
    parameter int unsigned long_cyc = press_release_pkg::long_cyc,
    parameter int unsigned max_cyc = press_release_pkg::max_cyc
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire press_release_pkg::mon_in_t mon_in,
    input wire press_release_pkg::setup_in_t set_in,
    output logic mon_release,
    output logic overrun_err,
    output logic press_release,
    output logic restart_required,
    output logic static_release_inv
);
    localparam logic [press_release_pkg::cnt_w-1:0] short_lim = press_release_pkg::cnt_w'(short_cyc);
    localparam logic [press_release_pkg::cnt_w-1:0] long_lim = press_release_pkg::cnt_w'(long_cyc);
    localparam logic [press_release_pkg::cnt_w-1:0] max_lim = press_release_pkg::cnt_w'(max_cyc);

    // Bus state: configuration, latched address phase and read data.
    press_release_pkg::cfg_t cfg_ff, nxt_cfg;
    logic wr_pend_ff, nxt_wr_pend;
    logic [7:0] wr_addr_ff, nxt_wr_addr;
    logic [31:0] rdata_ff, nxt_rdata;
    logic clear_cmd; // One-cycle error clear request from software.
    logic addr_ok; // A valid transfer is in its address phase.

    // Previous-cycle copies of every monitor and setup input, for edge detection.
    press_release_pkg::mon_in_t mon_prev_ff;
    press_release_pkg::setup_in_t set_prev_ff;

    // Monitor state.
    logic mon_rel_ff, nxt_mon_rel;
    logic err_ff, nxt_err;
    logic drive_ok_ff, nxt_drive_ok; // Drive rose inside the current window.
    logic window_ff, nxt_window; // Top has risen, stop cam not yet fallen.

    // Setup state.
    logic rel_ff, nxt_rel;
    logic req_ff, nxt_req;
    logic init_ff, nxt_init; // High only in the first cycle after reset.
    logic inv_ff, nxt_inv;
    logic [press_release_pkg::cnt_w-1:0] cnt_ff, nxt_cnt;

    // Edge terms, each the current input against last cycle's copy.
    logic scc_fall, top_rise, drive_rise, inh_fall, start_rise, top2_rise, rst_fall;

    assign scc_fall = mon_prev_ff.stop_cam_contact & ~mon_in.stop_cam_contact;
    assign top_rise = mon_in.top_pos & ~mon_prev_ff.top_pos;
    assign drive_rise = mon_in.drive_released & ~mon_prev_ff.drive_released;
    assign inh_fall = mon_prev_ff.mon_inhibit & ~mon_in.mon_inhibit;
    assign start_rise = set_in.start_cmd & ~set_prev_ff.start_cmd;
    assign top2_rise = set_in.top_in & ~set_prev_ff.top_in;
    assign rst_fall = set_prev_ff.restart & ~set_in.restart;

    // Zero-wait slave: every transfer completes in one data cycle, always OKAY.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;
    assign addr_ok = hsel & htrans[1] & hready;
    assign clear_cmd = wr_pend_ff & (wr_addr_ff == press_release_pkg::cmd_offs)
                       & hwdata[press_release_pkg::cmd_clear_bit];

    // Bus next-state: writes land in the data phase, reads are fetched in the
    // address phase so that read data comes straight from a flip-flop.
    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_wr_pend = addr_ok & hwrite;
        nxt_wr_addr = haddr[7:0];
        nxt_rdata = rdata_ff;
        if (wr_pend_ff && wr_addr_ff == press_release_pkg::ctrl_offs) begin
            // The interlock, stroke and pulse choices steer the setup stage.
            nxt_cfg = press_release_pkg::cfg_t'(hwdata[5:0]);
        end
        if (addr_ok && !hwrite) begin
            unique case (haddr[7:0])
                press_release_pkg::ctrl_offs: nxt_rdata = {26'h000_0000, cfg_ff};
                press_release_pkg::status_offs: nxt_rdata = {27'h000_0000, inv_ff, req_ff,
                                                             rel_ff, err_ff, mon_rel_ff};
                default: nxt_rdata = 32'h0000_0000; // Unmapped and write-only read zero.
            endcase
        end
    end

    // Bus registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_ff <= press_release_pkg::cfg_reset;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rdata_ff <= 32'h0000_0000;
        end else begin
            cfg_ff <= nxt_cfg;
            wr_pend_ff <= nxt_wr_pend;
            wr_addr_ff <= nxt_wr_addr;
            rdata_ff <= nxt_rdata;
        end
    end

    // Input history; the neighbours run on this clock, so no synchroniser.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mon_prev_ff <= '0;
            set_prev_ff <= '0;
        end else begin
            mon_prev_ff <= mon_in;
            set_prev_ff <= set_in;
        end
    end

    // Monitor next-state. The window opens at top rise and closes at the stop
    // cam falling edge, where the drive must have risen or still be high.
    always_comb begin
        nxt_mon_rel = mon_rel_ff;
        nxt_err = err_ff;
        nxt_drive_ok = drive_ok_ff;
        nxt_window = window_ff;
        if (top_rise) begin
            nxt_window = 1'b1;
            nxt_drive_ok = mon_in.drive_released & ~mon_prev_ff.drive_released;
        end else if (window_ff && drive_rise) begin
            nxt_drive_ok = 1'b1;
        end
        if (mon_in.mon_inhibit && err_ff) begin
            // A pending error may be cleared only while monitoring is inhibited.
            if (clear_cmd) begin
                nxt_err = 1'b0;
            end
            nxt_mon_rel = 1'b0;
        end else if (mon_in.mon_inhibit) begin
            // Checks suspended; error output untouched.
            nxt_mon_rel = 1'b0;
        end else if (inh_fall && !err_ff) begin
            // Same as leaving stop for run: release comes back.
            nxt_mon_rel = 1'b1;
        end else if (scc_fall && cfg_ff.scc_en) begin
            if (!(drive_ok_ff || drive_rise || mon_in.drive_released)) begin
                nxt_err = 1'b1;
                nxt_mon_rel = 1'b0;
            end
        end
        if (err_ff) begin
            nxt_mon_rel = 1'b0; // An error keeps release off until the error is cleared.
        end
        if (scc_fall) begin
            nxt_window = 1'b0;
            nxt_drive_ok = 1'b0;
        end
    end

    // Monitor registers. Release comes up at reset as after stop-to-run.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mon_rel_ff <= 1'b1;
            err_ff <= 1'b0;
            drive_ok_ff <= 1'b0;
            window_ff <= 1'b0;
        end else begin
            mon_rel_ff <= nxt_mon_rel;
            err_ff <= nxt_err;
            drive_ok_ff <= nxt_drive_ok;
            window_ff <= nxt_window;
        end
    end

    // Setup next-state. Stop conditions are checked first and beat a start
    // request in the same cycle, the safe order for a press drive.
    always_comb begin
        logic lim_ok;
        logic start_ok;
        lim_ok = 1'b0;
        start_ok = 1'b0;
        nxt_rel = rel_ff;
        nxt_req = req_ff;
        nxt_init = 1'b0;
        nxt_inv = ~set_in.static_release;
        nxt_cnt = '0;
        // Measure the restart pulse; saturate just beyond the upper limit.
        if (set_in.restart) begin
            nxt_cnt = (cnt_ff > max_lim) ? cnt_ff : cnt_ff + 1'b1;
        end
        lim_ok = (cnt_ff >= (cfg_ff.long_pulse ? long_lim : short_lim))
                 && (cnt_ff <= max_lim);
        if (rst_fall && lim_ok) begin
            nxt_req = 1'b0;
        end
        if (init_ff && cfg_ff.interlock != press_release_pkg::lock_never) begin
            nxt_req = 1'b1;
        end
        // Start release only matters while release is off.
        start_ok = !cfg_ff.start_rel_used || set_in.start_release;
        if (!set_in.static_release) begin
            nxt_rel = 1'b0;
            if (rel_ff && cfg_ff.interlock != press_release_pkg::lock_never) begin
                nxt_req = 1'b1;
            end
        end else if (rel_ff && !set_in.start_cmd) begin
            nxt_rel = 1'b0;
            if (cfg_ff.interlock == press_release_pkg::lock_static_or_start
                || cfg_ff.interlock == press_release_pkg::lock_always) begin
                nxt_req = 1'b1;
            end
        end else if (rel_ff && cfg_ff.single_stroke && top2_rise) begin
            nxt_rel = 1'b0;
            if (cfg_ff.interlock == press_release_pkg::lock_static_or_top
                || cfg_ff.interlock == press_release_pkg::lock_always) begin
                nxt_req = 1'b1;
            end
        end else if (!rel_ff && !req_ff && !init_ff && start_rise && start_ok) begin
            nxt_rel = 1'b1;
        end
    end

    // Setup registers: release and pending flag start low.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rel_ff <= 1'b0;
            req_ff <= 1'b0;
            init_ff <= 1'b1;
            inv_ff <= 1'b1;
            cnt_ff <= 'd0;
        end else begin
            rel_ff <= nxt_rel;
            req_ff <= nxt_req;
            init_ff <= nxt_init;
            inv_ff <= nxt_inv;
            cnt_ff <= nxt_cnt;
        end
    end

    assign mon_release = mon_rel_ff;
    assign overrun_err = err_ff;
    assign press_release = rel_ff;
    assign restart_required = req_ff;
    assign static_release_inv = inv_ff;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_overrun_disabled: assert property (!cfg_ff.scc_en && !err_ff |=> !err_ff)
        else $error("overrun error raised with stop cam unused");
    // A falling inhibit in the same cycle restarts monitoring, so it is excluded here.
    a_overrun_raise: assert property (scc_fall && cfg_ff.scc_en && !mon_in.mon_inhibit && !inh_fall
        && !drive_ok_ff && !mon_in.drive_released && !drive_rise
        |=> err_ff && !mon_rel_ff)
        else $error("missed overrun");
    a_drive_accept: assert property (scc_fall && mon_in.drive_released && !err_ff
        |=> !err_ff)
        else $error("overrun despite drive released");
    a_inhibit_hold: assert property (mon_in.mon_inhibit |=> !mon_rel_ff[*1])
        else $error("release high under inhibit");
    a_inhibit_clear: assert property (mon_in.mon_inhibit && err_ff && clear_cmd
        |=> !err_ff)
        else $error("error not cleared");
    a_inhibit_resume: assert property (inh_fall && !err_ff |=> mon_rel_ff)
        else $error("release not restored after inhibit");
    a_static_drop: assert property (!set_in.static_release |=> !rel_ff && inv_ff)
        else $error("release high without static release");
    a_stroke_end: assert property (cfg_ff.single_stroke && top2_rise |=> !rel_ff)
        else $error("release survived top rise");
    a_start_gate: assert property (!rel_ff && cfg_ff.start_rel_used && !set_in.start_release
        |=> !rel_ff)
        else $error("release set without start release");
    a_pending_gate: assert property ($rose(rel_ff) |-> $past(!req_ff) && $past(start_rise))
        else $error("release set while restart pending");

    c_overrun: cover property (scc_fall ##1 err_ff);
    c_restart: cover property (req_ff ##1 !req_ff);
    c_release: cover property (!rel_ff ##1 rel_ff);
endmodule // press_cycle_release_control
`default_nettype wire

//--- logic/press_release_pkg.sv
`default_nettype none
package press_release_pkg;
    // Register byte offsets on the AHB-Lite slave.
    localparam logic [7:0] ctrl_offs = 8'h00;
    localparam logic [7:0] status_offs = 8'h04;
    localparam logic [7:0] cmd_offs = 8'h08;
    // Control register field positions.
    localparam int unsigned ctrl_scc_en_bit = 0;
    localparam int unsigned ctrl_start_rel_bit = 1;
    localparam int unsigned ctrl_stroke_bit = 2;
    localparam int unsigned ctrl_long_pulse_bit = 3;
    localparam int unsigned ctrl_interlock_lsb = 4;
    // Command register: writing one here clears a pending overrun error while monitoring is inhibited.
    localparam int unsigned cmd_clear_bit = 0;
    // Restart interlock choices.
    typedef enum logic [1:0] {
        lock_never = 2'b00,
        lock_static_or_start = 2'b01,
        lock_static_or_top = 2'b10,
        lock_always = 2'b11
    } interlock_t;
    // Configuration as software writes it.
    typedef struct packed {
        interlock_t interlock;
        logic long_pulse;
        logic single_stroke;
        logic start_rel_used;
        logic scc_en;
    } cfg_t;
    localparam cfg_t cfg_reset = '{interlock: lock_never, default: 1'b0};
    // Inputs of the contact monitor part.
    typedef struct packed {
        logic stop_cam_contact;
        logic top_pos;
        logic drive_released;
        logic mon_inhibit;
    } mon_in_t;
    // Inputs of the setup stage.
    typedef struct packed {
        logic static_release;
        logic start_release;
        logic start_cmd;
        logic top_in;
        logic restart;
    } setup_in_t;
    // Restart pulse timing, as printed, and the clock rate.
    localparam int unsigned clk_hz = 10_000_000;
    localparam int unsigned min_short_ms = 100;
    localparam int unsigned min_long_ms = 350;
    localparam int unsigned max_pulse_s = 30;
    localparam int unsigned short_cyc = min_short_ms * (clk_hz / 1000);
    localparam int unsigned long_cyc = min_long_ms * (clk_hz / 1000);
    localparam int unsigned max_cyc = max_pulse_s * clk_hz;
    localparam int unsigned cnt_w = 29;
endpackage
`default_nettype wire

//--- verification/press_neighbour_model.sv
`timescale 1ns/100ps
`default_nettype none
// Neighbouring blocks around the release logic, reduced to their wiring.
module press_neighbour_model (
    input wire logic mon_release,
    input wire logic press_release,
    input wire logic top_pos,
    output logic static_release,
    output logic drive_released,
    output logic top_in
);
    // The monitor release gates the setup stage, so an overrun stops the drive.
    assign static_release = mon_release;
    // The drive enable loops back so the monitor can tell running from stopped.
    assign drive_released = press_release;
    // Top position comes only from the monitor's own contact source.
    assign top_in = top_pos;
endmodule // press_neighbour_model
`default_nettype wire

//--- verification/tb_press_cycle_release_control.sv
`timescale 1ns/100ps
`default_nettype none
module tb_press_cycle_release_control;
    // Bench-driven inputs; each but hclk changes by non-blocking assignment at a rising edge.
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd;
    logic [1:0] htrans = 2'b00;
    logic stop_cam = 1'b1, top_pos = 1'b0, inhibit = 1'b0;
    logic start_rel = 1'b0, start_cmd = 1'b0, restart = 1'b0;
    wire logic hreadyout, hresp, mon_release, overrun_err, press_release;
    wire logic restart_required, static_inv, drv, stat, top_in;
    wire logic [31:0] hrdata;
    wire press_release_pkg::mon_in_t mon_in;
    wire press_release_pkg::setup_in_t set_in;
    int err_count = 0;
    int compares = 0;
    assign mon_in = {stop_cam, top_pos, drv, inhibit};
    assign set_in = {stat, start_rel, start_cmd, top_in, restart};
    // Short pulse counts keep the run brief; all expectations use 10, 35 and 300.
    press_cycle_release_control #(.short_cyc(10), .long_cyc(35), .max_cyc(300))
        press_cycle_release_control_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .mon_in(mon_in), .set_in(set_in), .mon_release(mon_release),
        .overrun_err(overrun_err), .press_release(press_release),
        .restart_required(restart_required), .static_release_inv(static_inv));
    press_neighbour_model press_neighbour_model_i (.mon_release(mon_release),
        .press_release(press_release), .top_pos(top_pos), .static_release(stat),
        .drive_released(drv), .top_in(top_in));
    // The clock flips every half period of 100 ns.
    always #50 hclk = ~hclk;
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One single-word transfer; waits on hready rather than assuming zero wait.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic pulse(input int n);
        restart <= 1'b1;
        tick(n);
        restart <= 1'b0;
        tick(3);
    endtask
    task automatic run_stop();
        start_cmd <= 1'b1;
        tick(2);
        chk("press_release on start", press_release, 1'b1);
        start_cmd <= 1'b0;
        tick(2);
        chk("press_release on stop", press_release, 1'b0);
    endtask
    // One press stroke past the stop cam, with or without the drive running.
    task automatic cam_cycle(input logic run, input logic exp_err);
        top_pos <= 1'b1;
        tick(2);
        if (run) begin
            start_cmd <= 1'b1;
            tick(3);
            start_cmd <= 1'b0;
            tick(3);
        end
        stop_cam <= 1'b0;
        tick(2);
        chk("overrun_err", overrun_err, exp_err);
        stop_cam <= 1'b1;
        top_pos <= 1'b0;
        tick(2);
    endtask
    task automatic t_reset();
        chk("press_release after reset", press_release, 1'b0);
        chk("hresp", hresp, 1'b0);
        chk("static_release_inv after reset", static_inv, 1'b0);
        bus(1'b1, 8'h04, 32'h0000_001f);
        bus(1'b0, 8'h04, 32'h0000_0000);
        chk("status", rd, 32'h0000_0001);
        bus(1'b0, 8'h0c, 32'h0000_0000);
        chk("unmapped read", rd, 32'h0000_0000);
        $display("reset test done");
    endtask
    task automatic t_start();
        bus(1'b1, 8'h00, 32'h0000_0002);
        bus(1'b0, 8'h00, 32'h0000_0000);
        chk("ctrl readback", rd, 32'h0000_0002);
        start_cmd <= 1'b1;
        tick(2);
        chk("press_release gated", press_release, 1'b0);
        start_cmd <= 1'b0;
        start_rel <= 1'b1;
        tick(2);
        run_stop();
        start_cmd <= 1'b1;
        tick(2);
        start_rel <= 1'b0;
        tick(2);
        chk("start release ignored", press_release, 1'b1);
        start_cmd <= 1'b0;
        bus(1'b1, 8'h00, 32'h0000_0004);
        start_cmd <= 1'b1;
        tick(2);
        top_pos <= 1'b1;
        tick(2);
        chk("single stroke", press_release, 1'b0);
        top_pos <= 1'b0;
        start_cmd <= 1'b0;
        tick(2);
        $display("start test done");
    endtask
    task automatic t_overrun();
        bus(1'b1, 8'h00, 32'h0000_0000);
        cam_cycle(1'b0, 1'b0);
        bus(1'b1, 8'h00, 32'h0000_0001);
        cam_cycle(1'b1, 1'b0);
        cam_cycle(1'b0, 1'b1);
        bus(1'b0, 8'h04, 32'h0000_0000);
        chk("status on error", rd, 32'h0000_0012);
        start_cmd <= 1'b1;
        tick(2);
        chk("static low refuses", press_release, 1'b0);
        start_cmd <= 1'b0;
        inhibit <= 1'b1;
        bus(1'b1, 8'h08, 32'h0000_0001);
        tick(2);
        chk("error cleared", overrun_err, 1'b0);
        inhibit <= 1'b0;
        tick(2);
        chk("mon_release back", mon_release, 1'b1);
        start_cmd <= 1'b1;
        tick(2);
        inhibit <= 1'b1;
        tick(3);
        chk("inhibit release", mon_release, 1'b0);
        chk("drive drops", press_release, 1'b0);
        inhibit <= 1'b0;
        start_cmd <= 1'b0;
        tick(3);
        $display("overrun test done");
    endtask
    task automatic t_interlock();
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 8'h00, 32'(i) << 4);
            run_stop();
            chk("restart pending", restart_required, 1'(i == 1 || i == 3));
            if (i == 1 || i == 3) begin
                start_cmd <= 1'b1;
                tick(2);
                chk("start refused", press_release, 1'b0);
                start_cmd <= 1'b0;
                pulse(5);
                chk("short pulse", restart_required, 1'b1);
                pulse(12);
                chk("valid pulse", restart_required, 1'b0);
            end
        end
        bus(1'b1, 8'h00, 32'h0000_0038);
        run_stop();
        pulse(20);
        chk("below long minimum", restart_required, 1'b1);
        pulse(40);
        chk("long pulse", restart_required, 1'b0);
        run_stop();
        pulse(310);
        chk("overlong pulse", restart_required, 1'b1);
        $display("interlock test done");
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        tick(10);
        hresetn <= 1'b1;
        tick(3);
        t_reset();
        t_start();
        t_overrun();
        t_interlock();
        wrap_up();
    end
    // The tests need about five hundred cycles; forty times that means a hang.
    initial begin
        #(20_000 * 100);
        err_count++;
        wrap_up();
    end
endmodule // tb_press_cycle_release_control
`default_nettype wire
